// *** asif_pkg.sv ***
package asif_pkg;

  // Register map of the input port control
  localparam logic [15:0] SIC_ADDR  = 16'h081f;
  localparam logic [7:0]  SIC_RESET = 8'h00;
  localparam int          ILP_BIT   = 4;
  localparam int          IBP_BIT   = 3;
  localparam int          MODE_MSB  = 2;

  // Port geometry
  localparam int WORD_W   = 24;
  localparam int RJ20_W   = 20;
  localparam int NUM_PINS = 4;
  localparam int NUM_CH   = 8;
  localparam int CNT_W    = 8;
  localparam int SLOT_LSB = 5;

  // MSB delays in bit clocks from the start of a half-frame or slot
  localparam logic [CNT_W-1:0] I2S_DELAY = 8'h01;
  localparam logic [CNT_W-1:0] LJ_DELAY  = 8'h00;
  localparam logic [4:0]       TDM_DELAY = 5'h01;
  localparam logic [CNT_W-1:0] WORD_LAST = 8'h17;
  localparam logic [CNT_W-1:0] CNT_IDLE  = 8'hff;
  localparam logic [2:0]       LAST_SLOT = 3'h7;

  // Input format codes
  typedef enum logic [2:0] {
    MODE_I2S  = 3'b000,
    MODE_LJ   = 3'b001,
    MODE_TDM  = 3'b010,
    MODE_RJ24 = 3'b011,
    MODE_RJ20 = 3'b100
  } asif_mode_t;

  // Control register fields as they cross to the bit clock domain
  typedef struct packed {
    logic       frame_pol;
    logic       bit_pol;
    logic [2:0] mode;
  } asif_cfg_t;

  typedef logic [NUM_CH-1:0][WORD_W-1:0] asif_words_t;

endpackage : asif_pkg

// *** asif_serial_in.sv ***
// Behaviour
// - I2S: polarity 0 takes left while frame clock low; 1 swaps.
// - TDM: frame starts after falling frame edge at 0, rising at 1.
// - Frame clock may be a pulse; first pulse edge starts the frame.
// - Bit polarity 0: data changes on falling edge; 1: on rising edge.
// - Justified modes carry left in the high phase at default polarity.
// - TDM slot MSB arrives one bit clock after the slot starts.
// - TDM frame holds eight slots, channels 0-3 then 4-7.
// - Control register at 2079, 8 bits, upper three zero, reset 0x00.
// - Mode 000 I2S, 001 LJ, 010 TDM, 011 RJ 24, 100 RJ 20.
`timescale 1ns/1ps
module asif_serial_in (
  input  wire logic                                   clk,
  input  wire logic                                   rst_n,
  input  wire logic [15:0]                            reg_addr,
  input  wire logic                                   reg_wr_en,
  input  wire logic                                   reg_rd_en,
  input  wire logic [7:0]                             reg_wdata,
  output logic      [7:0]                             reg_rdata,
  input  wire logic                                   serial_bit_clk,
  input  wire logic                                   input_frame_clock,
  input  wire logic [asif_pkg::NUM_PINS-1:0]          serial_data_inputs,
  output asif_pkg::asif_words_t                       ch_words,
  output logic                                        frame_done
);

  // System clock domain: control register
  asif_pkg::asif_cfg_t cfg_q, cfg_d;
  logic [7:0]          rdata_q, rdata_d;
  logic                addr_hit;
  logic                wr_tog_q, wr_tog_d;

  assign addr_hit = (reg_addr == asif_pkg::SIC_ADDR);

  // Register write and read-back; upper bits dropped on write
  always_comb begin
    cfg_d    = cfg_q;
    rdata_d  = rdata_q;
    wr_tog_d = wr_tog_q;
    if (reg_wr_en && addr_hit) begin
      wr_tog_d        = ~wr_tog_q; // Tells the bit clock side to reload
      cfg_d.frame_pol = reg_wdata[asif_pkg::ILP_BIT];
      cfg_d.bit_pol   = reg_wdata[asif_pkg::IBP_BIT];
      cfg_d.mode      = reg_wdata[asif_pkg::MODE_MSB:0];
    end
    if (reg_rd_en) begin
      rdata_d = addr_hit ? {3'h0, cfg_q} : 8'h00;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q    <= asif_pkg::asif_cfg_t'(asif_pkg::SIC_RESET[4:0]);
      rdata_q  <= 8'h00;
      wr_tog_q <= 1'b0;
    end else begin
      cfg_q    <= cfg_d;
      rdata_q  <= rdata_d;
      wr_tog_q <= wr_tog_d;
    end
  end

  assign reg_rdata = rdata_q;

  // Bit clock domain
  // A write flips a toggle; once it has passed two flops the whole register
  // is taken at once, so no field is seen half updated. Limitation: writes
  // closer than three bit clocks may load a mix, the later toggle repairs it
  asif_pkg::asif_cfg_t cfg_s_q, cfg_s_d;
  logic                wt_m_q, wt_s_q, wt_p_q;
  logic                cfg_load;

  assign cfg_load = wt_s_q ^ wt_p_q;

  always_comb begin
    cfg_s_d = cfg_s_q;
    if (cfg_load) begin
      cfg_s_d = cfg_q;
    end
  end

  always_ff @(posedge serial_bit_clk or negedge rst_n) begin
    if (!rst_n) begin
      wt_m_q  <= 1'b0;
      wt_s_q  <= 1'b0;
      wt_p_q  <= 1'b0;
      cfg_s_q <= asif_pkg::asif_cfg_t'(asif_pkg::SIC_RESET[4:0]);
    end else begin
      wt_m_q  <= wr_tog_q;
      wt_s_q  <= wt_m_q;
      wt_p_q  <= wt_s_q;
      cfg_s_q <= cfg_s_d;
    end
  end

  // Sample the pins on both edges; the selected edge feeds the deserialiser
  logic                              lr_r_q, lr_f_q;
  logic [asif_pkg::NUM_PINS-1:0]     sd_r_q, sd_f_q;

  always_ff @(posedge serial_bit_clk or negedge rst_n) begin
    if (!rst_n) begin
      lr_r_q <= 1'b0;
      sd_r_q <= '0;
    end else begin
      lr_r_q <= input_frame_clock;
      sd_r_q <= serial_data_inputs;
    end
  end

  always_ff @(negedge serial_bit_clk or negedge rst_n) begin
    if (!rst_n) begin
      lr_f_q <= 1'b0;
      sd_f_q <= '0;
    end else begin
      lr_f_q <= input_frame_clock;
      sd_f_q <= serial_data_inputs;
    end
  end

  // Data changing on falling edge means capture on rising, and vice versa
  logic                          lr_smp;
  logic [asif_pkg::NUM_PINS-1:0] sd_smp;

  assign lr_smp = cfg_s_q.bit_pol ? lr_f_q : lr_r_q;
  assign sd_smp = cfg_s_q.bit_pol ? sd_f_q : sd_r_q;

  // Mode decode
  logic is_tdm, is_just, is_rj, is_valid_mode;
  logic [asif_pkg::CNT_W-1:0] msb_delay;

  always_comb begin
    is_tdm        = 1'b0;
    is_just       = 1'b0;
    is_rj         = 1'b0;
    is_valid_mode = 1'b1;
    msb_delay     = asif_pkg::I2S_DELAY;
    case (asif_pkg::asif_mode_t'(cfg_s_q.mode))
      asif_pkg::MODE_I2S:  msb_delay = asif_pkg::I2S_DELAY;
      asif_pkg::MODE_LJ: begin
        is_just   = 1'b1;
        msb_delay = asif_pkg::LJ_DELAY;
      end
      asif_pkg::MODE_TDM:  is_tdm = 1'b1;
      asif_pkg::MODE_RJ24,
      asif_pkg::MODE_RJ20: begin
        is_just = 1'b1;
        is_rj   = 1'b1;
      end
      default: is_valid_mode = 1'b0; // Reserved codes capture nothing
    endcase
  end

  // Framing: edge detection, bit counter, channel side
  logic                       lr_prev_q, lr_prev_d;
  logic [asif_pkg::CNT_W-1:0] cnt_q, cnt_d;
  logic                       right_q, right_d;
  logic                       started_q, started_d;
  logic                       lr_rise, lr_fall, tdm_start, half_start;
  logic                       left_lvl, rj_latch;
  logic [2:0]                 slot;

  assign lr_rise   = lr_smp & ~lr_prev_q;
  assign lr_fall   = ~lr_smp & lr_prev_q;
  // Only the selected edge counts, so a pulse frame's trailing edge is ignored
  assign tdm_start = cfg_s_q.frame_pol ? lr_rise : lr_fall;
  assign half_start = is_tdm ? tdm_start : (lr_rise | lr_fall);
  // Justified modes invert the level that carries the left channel
  assign left_lvl  = cfg_s_q.frame_pol ^ is_just;
  assign slot      = cnt_d[asif_pkg::CNT_W-1:asif_pkg::SLOT_LSB];
  // Right justified words end at the half boundary: latch the previous half
  assign rj_latch  = is_rj && half_start && started_q;

  always_comb begin
    lr_prev_d = lr_smp;
    right_d   = right_q;
    started_d = started_q;
    if (!is_valid_mode || cfg_load) begin // A new format waits for a fresh edge
      cnt_d     = asif_pkg::CNT_IDLE;
      started_d = 1'b0;
    end else if (half_start) begin
      cnt_d     = '0;
      started_d = 1'b1;
      right_d   = (lr_smp != left_lvl);
    end else if (cnt_q != asif_pkg::CNT_IDLE) begin
      cnt_d = cnt_q + 8'h01;
    end else begin
      cnt_d = cnt_q;
    end
  end

  always_ff @(posedge serial_bit_clk or negedge rst_n) begin
    if (!rst_n) begin
      lr_prev_q <= 1'b0;
      cnt_q     <= asif_pkg::CNT_IDLE;
      right_q   <= 1'b0;
      started_q <= 1'b0;
    end else begin
      lr_prev_q <= lr_prev_d;
      cnt_q     <= cnt_d;
      right_q   <= right_d;
      started_q <= started_d;
    end
  end

  // Per-pin shift registers, MSB first
  logic [asif_pkg::NUM_PINS-1:0][asif_pkg::WORD_W-1:0] sh_q, sh_d;

  genvar gp;
  generate
    for (gp = 0; gp < asif_pkg::NUM_PINS; gp++) begin : g_pin
      always_comb begin
        sh_d[gp] = {sh_q[gp][asif_pkg::WORD_W-2:0], sd_smp[gp]};
      end
    end
  endgenerate

  always_ff @(posedge serial_bit_clk or negedge rst_n) begin
    if (!rst_n) begin
      sh_q <= '0;
    end else begin
      sh_q <= sh_d;
    end
  end

  // Word latch per channel: stereo pins give pairs, TDM fills all slots
  asif_pkg::asif_words_t      words_q, words_d;
  logic [asif_pkg::NUM_CH-1:0] latch;
  logic                       stereo_hit;
  logic [asif_pkg::WORD_W-1:0] rj_word [asif_pkg::NUM_PINS];

  assign stereo_hit = !is_tdm && !is_rj && is_valid_mode &&
                      (cnt_d == msb_delay + asif_pkg::WORD_LAST);

  genvar gc;
  generate
    for (gc = 0; gc < asif_pkg::NUM_PINS; gc++) begin : g_rj
      // 20-bit words are left aligned in the 24-bit result
      assign rj_word[gc] = (cfg_s_q.mode == asif_pkg::MODE_RJ20) ?
                           {sh_q[gc][asif_pkg::RJ20_W-1:0], 4'h0} : sh_q[gc];
    end
    for (gc = 0; gc < asif_pkg::NUM_CH; gc++) begin : g_ch
      always_comb begin
        words_d[gc] = words_q[gc];
        latch[gc]   = 1'b0;
        if (is_tdm) begin
          // Whole stream on the first input; MSB one bit into the slot
          if (slot == 3'(gc) && cnt_d[asif_pkg::SLOT_LSB-1:0] ==
              5'(asif_pkg::TDM_DELAY + 5'(asif_pkg::WORD_LAST))) begin
            words_d[gc] = sh_d[0];
            latch[gc]   = 1'b1;
          end
        end else if (rj_latch && right_q == 1'(gc % 2)) begin
          words_d[gc] = rj_word[gc/2];
          latch[gc]   = 1'b1;
        end else if (stereo_hit && right_d == 1'(gc % 2)) begin
          words_d[gc] = sh_d[gc/2];
          latch[gc]   = 1'b1;
        end
      end
    end
  endgenerate

  // Frame complete when the right channel or the last slot is latched
  logic tog_q, tog_d;

  always_comb begin
    tog_d = tog_q;
    if (is_tdm ? (latch[asif_pkg::NUM_CH-1] && slot == asif_pkg::LAST_SLOT)
               : latch[1]) begin
      tog_d = ~tog_q;
    end
  end

  always_ff @(posedge serial_bit_clk or negedge rst_n) begin
    if (!rst_n) begin
      words_q <= '0;
      tog_q   <= 1'b0;
    end else begin
      words_q <= words_d;
      tog_q   <= tog_d;
    end
  end

  // Crossing back to the system clock
  // Words stay stable for many bit clocks after the toggle, so they are
  // taken as a bus once the synchronised toggle is seen
  logic                 tog_m_q, tog_s_q, tog_p_q;
  asif_pkg::asif_words_t out_q, out_d;
  logic                 done_q, done_d;

  always_comb begin
    out_d  = out_q;
    done_d = tog_s_q ^ tog_p_q;
    if (tog_s_q ^ tog_p_q) begin
      out_d = words_q;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tog_m_q <= 1'b0;
      tog_s_q <= 1'b0;
      tog_p_q <= 1'b0;
      out_q   <= '0;
      done_q  <= 1'b0;
    end else begin
      tog_m_q <= tog_q;
      tog_s_q <= tog_m_q;
      tog_p_q <= tog_s_q;
      out_q   <= out_d;
      done_q  <= done_d;
    end
  end

  assign ch_words   = out_q;
  assign frame_done = done_q;

endmodule : asif_serial_in

// *** asif_serial_in_checker.sv ***
`timescale 1ns/1ps
module asif_serial_in_checker (
  input wire logic                              clk,
  input wire logic                              rst_n,
  input wire logic [15:0]                       reg_addr,
  input wire logic                              reg_wr_en,
  input wire logic                              reg_rd_en,
  input wire logic [7:0]                        reg_wdata,
  input wire logic [7:0]                        reg_rdata,
  input wire logic                              serial_bit_clk,
  input wire logic                              input_frame_clock,
  input wire logic [asif_pkg::NUM_PINS-1:0]     serial_data_inputs,
  input wire asif_pkg::asif_words_t             ch_words,
  input wire logic                              frame_done
);
  logic       hit;
  logic [7:0] shadow_d;
  logic [7:0] shadow_q;

  // Expected register image; upper bits are never stored
  assign hit = reg_addr == asif_pkg::SIC_ADDR;
  always_comb shadow_d = (reg_wr_en && hit) ? (reg_wdata & 8'h1f) : shadow_q;
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n) shadow_q <= asif_pkg::SIC_RESET;
    else shadow_q <= shadow_d;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Register side
  rd_upper_zero_a: assert property (reg_rdata[7:5] == 3'h0)
    else $error("read data upper bits not zero");
  rd_hit_a: assert property (reg_rd_en && hit |=> reg_rdata == $past(shadow_q))
    else $error("register read mismatch");
  rd_miss_a: assert property (reg_rd_en && !hit |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  rd_hold_a: assert property (!reg_rd_en |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  wr_rd_pair_a: assert property (reg_wr_en && hit ##1 reg_rd_en && hit
    |=> reg_rdata == ($past(reg_wdata, 2) & 8'h1f)) else $error("written value not read back");
  // Frame output side; words only move together with the completion pulse
  done_pulse_a: assert property (frame_done |=> !frame_done [*8])
    else $error("frame pulse too long or too close");
  words_move_a: assert property (!$stable(ch_words) |-> frame_done)
    else $error("channel words changed without frame pulse");
  words_stay_a: assert property (frame_done |=> $stable(ch_words) [*8])
    else $error("channel words unstable after frame");
endmodule : asif_serial_in_checker

bind asif_serial_in asif_serial_in_checker chk (.clk, .rst_n, .reg_addr, .reg_wr_en,
  .reg_rd_en, .reg_wdata, .reg_rdata, .serial_bit_clk, .input_frame_clock,
  .serial_data_inputs, .ch_words, .frame_done);

// *** asif_source_model.sv ***
`timescale 1ns/1ps
module asif_source_model (
  input  wire logic                          run,
  input  wire asif_pkg::asif_cfg_t           cfg,
  input  wire asif_pkg::asif_words_t         words,
  output logic                               bclk,
  output logic                               fclk,
  output logic [asif_pkg::NUM_PINS-1:0]      sdata,
  output logic                               busy
);
  logic tdm;
  logic lft;
  int   w;

  // Left-channel frame level flips for justified modes
  assign tdm = cfg.mode == asif_pkg::MODE_TDM;
  assign lft = cfg.frame_pol ^ (cfg.mode != asif_pkg::MODE_I2S);
  assign w   = cfg.mode == asif_pkg::MODE_RJ20 ? 20 : 24;

  // Pad bits toggle so that stale data never looks valid
  function automatic logic bit_at(int p, int b);
    int off;
    int k;
    if (tdm && p != 0) return b[1];
    off = cfg.mode == asif_pkg::MODE_I2S ? 1 : cfg.mode == asif_pkg::MODE_LJ ? 0 : 32 - w;
    k = tdm ? b % 32 - 1 : b % 32 - off;
    if (k < 0 || k >= w) return b[0];
    return words[tdm ? b / 32 : 2 * p + b / 32][23 - k];
  endfunction : bit_at

  // Clocks stand still between runs; a short preamble lets the config settle
  initial begin
    bclk  = 1'b0;
    fclk  = 1'b0;
    sdata = '0;
    busy  = 1'b0;
    forever begin
      wait (run);
      busy = 1'b1;
      bclk = !cfg.bit_pol;
      fclk = tdm ? !cfg.frame_pol : !lft;
      repeat (4) begin
        #15 bclk = ~bclk;
        #15 bclk = ~bclk;
      end
      while (run) begin
        for (int b = 0; b < (tdm ? 256 : 64); b++) begin
          bclk = cfg.bit_pol;
          fclk = tdm ? ((b == 0) == cfg.frame_pol) : ((b < 32) == lft);
          for (int p = 0; p < asif_pkg::NUM_PINS; p++) sdata[p] = bit_at(p, b);
          #15 bclk = ~bclk;
          #15;
        end
      end
      sdata = ~sdata;
      busy  = 1'b0;
    end
  end
endmodule : asif_source_model

// *** asif_tb.sv ***
`timescale 1ns/1ps
module testbench;
  logic                  clk;
  logic                  rst_n;
  logic [15:0]           reg_addr;
  logic                  reg_wr_en;
  logic                  reg_rd_en;
  logic [7:0]            reg_wdata;
  logic [7:0]            reg_rdata;
  logic                  serial_bit_clk;
  logic                  input_frame_clock;
  logic [3:0]            serial_data_inputs;
  asif_pkg::asif_words_t ch_words;
  logic                  frame_done;
  asif_pkg::asif_words_t words;
  logic [7:0]            v;
  logic                  run;
  logic                  busy;
  int                    n_mismatch;
  int                    comparisons;
  int                    seed;
  int                    d;

  // Clock inverted every half period
  always #5 clk = ~clk;

  asif_serial_in dut (.clk, .rst_n, .reg_addr, .reg_wr_en, .reg_rd_en, .reg_wdata,
    .reg_rdata, .serial_bit_clk, .input_frame_clock, .serial_data_inputs, .ch_words,
    .frame_done);
  asif_source_model src (.run, .cfg(v[4:0]), .words, .bclk(serial_bit_clk),
    .fclk(input_frame_clock), .sdata(serial_data_inputs), .busy);

  task automatic chk(logic [191:0] e, logic [191:0] g);
    comparisons++;
    if (e !== g) begin
      n_mismatch++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk

  // The write strobe is dropped by the read that follows; a read drops its own strobe
  task automatic wr(logic [15:0] a, logic [7:0] x);
    @(negedge clk);
    reg_addr  = a;
    reg_wdata = x;
    reg_wr_en = 1'b1;
  endtask : wr

  task automatic rd_chk(logic [15:0] a, logic [7:0] e);
    @(negedge clk);
    reg_wr_en = 1'b0;
    reg_addr  = a;
    reg_rd_en = 1'b1;
    @(negedge clk);
    reg_rd_en = 1'b0;
    @(negedge clk);
    chk(e, reg_rdata);
  endtask : rd_chk

  task automatic wait_done;
    for (int k = 0; k < 3000 && frame_done !== 1'b1; k++) @(negedge clk);
    chk(1'b1, frame_done);
    @(negedge clk);
  endtask : wait_done

  // RJ20 keeps the top 20 bits, low nibble zero
  function automatic asif_pkg::asif_words_t exp_words(logic [7:0] x);
    exp_words = words;
    if (x[2:0] == asif_pkg::MODE_RJ20) for (int i = 0; i < 8; i++) exp_words[i][3:0] = 4'h0;
  endfunction : exp_words

  // Second completed frame is compared; the first may hold a stale half
  task automatic run_case;
    for (int i = 0; i < 8; i++) words[i] = 24'($random(seed));
    wr(asif_pkg::SIC_ADDR, v);
    rd_chk(asif_pkg::SIC_ADDR, v & 8'h1f);
    run = 1'b1;
    wait_done;
    wait_done;
    run = 1'b0;
    chk(exp_words(v), ch_words);
    wait (!busy);
  endtask : run_case

  task automatic complete_run;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : complete_run

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    reg_addr = 16'h0000;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_wdata = 8'h00;
    v = 8'h00;
    words = '0;
    run = 1'b0;
    n_mismatch = 0;
    comparisons = 0;
    seed = 74;
    repeat (16) @(posedge clk);
    @(negedge clk) rst_n = 1'b1;
    rd_chk(asif_pkg::SIC_ADDR, 8'h00);
    wr(16'h081e, 8'h1f);
    rd_chk(16'h081e, 8'h00);
    rd_chk(asif_pkg::SIC_ADDR, 8'h00);
    for (int m = 0; m < 5; m++) begin
      for (int p = 0; p < 4; p++) begin
        v = {3'($random(seed)), 2'(p), 3'(m)};
        run_case;
      end
    end
    // Reserved format captures nothing
    v = 8'h05;
    wr(asif_pkg::SIC_ADDR, v);
    rd_chk(asif_pkg::SIC_ADDR, 8'h05);
    run = 1'b1;
    d = 0;
    // The previous format may still close its last half before the new one loads
    repeat (30) @(negedge clk);
    repeat (400) begin
      @(negedge clk);
      if (frame_done !== 1'b0) d++;
    end
    run = 1'b0;
    chk(0, d);
    complete_run;
  end

  // Watchdog well beyond the expected run time
  initial begin
    #500us;
    n_mismatch++;
    complete_run;
  end
endmodule : testbench
